// *** rtl/udqt_defs.svh ***
/*
 * register field positions, reset values and prescaler taps of the
 * up/down quadrature timer.
 * assumes inclusion by bare name from the timer's source files.
 */
`ifndef UDQT_DEFS_SVH
`define UDQT_DEFS_SVH

// ---------------------------------------------------------------
// unit mode register fields
// ---------------------------------------------------------------
`define UDQT_UMR_MODE 7
`define UDQT_UMR_XCLR_EN 6
`define UDQT_UMR_CEDGE_HI 5
`define UDQT_UMR_CEDGE_LO 4
`define UDQT_UMR_PEDGE_HI 1
`define UDQT_UMR_PEDGE_LO 0
`define UDQT_UMR_MASK 8'hf3
`define UDQT_UMR_RESET 8'h00

// ---------------------------------------------------------------
// counter control register fields
// ---------------------------------------------------------------
`define UDQT_CCR_RUN 7
`define UDQT_CCR_MCLR_EN 6
`define UDQT_CCR_UDF 5
`define UDQT_CCR_OVF 4
`define UDQT_CCR_DIR 3
`define UDQT_CCR_IE 2
`define UDQT_CCR_SEL_HI 1
`define UDQT_CCR_SEL_LO 0
`define UDQT_CCR_RESET 8'h00

// ---------------------------------------------------------------
// counter values and prescaler taps
// ---------------------------------------------------------------
`define UDQT_CNT_ZERO 16'h0000
`define UDQT_CNT_ONE 16'h0001
`define UDQT_CNT_MAX 16'hffff
`define UDQT_GP_TAPS 6
`define UDQT_UDC_TAP_BASE 2
`define UDQT_UDC_SEL_NONE 2'h3

`endif

// *** rtl/udqt_pkg.sv ***
/*
 * types shared by the up/down quadrature timer modules.
 * assumes nothing of its surroundings.
 */
package udqt_pkg;

	// edge and level view of one synchronised pin
	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} udqt_pin_t;

	// external counting modes, in field-code order
	typedef enum logic [1:0] {
		UDQT_EXT_M1,
		UDQT_EXT_M2,
		UDQT_EXT_M3,
		UDQT_EXT_M4
	} udqt_ext_mode_t;

endpackage

// *** rtl/udqt_pin_sync.sv ***
/*
 * two-flop synchronisers with edge detection for the external pins.
 * assumes asynchronous pins; outputs are in the clk_i domain.
 */
`timescale 1ns/1ps
`default_nettype none

module udqt_pin_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// raw pins and their synchronised view
	input wire logic [W-1:0] pin_i,
	output var udqt_pkg::udqt_pin_t pin_o [W]
);
	import udqt_pkg::*;

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// first flop feeds only the second; third keeps the old level
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// per-pin edge decode
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_pin
			// level, rise, fall in struct order
			assign pin_o[g] = {sync_q[g], sync_q[g] & ~prev_q[g],
				~sync_q[g] & prev_q[g]};
		end
	endgenerate

endmodule

`default_nettype wire

// *** rtl/udqt_prescaler.sv ***
/*
 * binary prescaler giving one-cycle ticks at clk/1 .. clk/2^(N-1).
 * assumes clear_i held while the counter is stopped, for alignment.
 */
`timescale 1ns/1ps
`default_nettype none

module udqt_prescaler #(
	parameter int N = 6
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// control and ticks
	input wire logic clear_i,
	output logic [N-1:0] tick_o
);
	logic [N-2:0] div_q;
	logic [N-2:0] div_d;

	// next divider value
	always_comb begin
		div_d = clear_i ? '0 : div_q + 1'b1;
	end

	// divider register
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// tick k fires when the low k bits are all ones
	assign tick_o[0] = ~clear_i;
	genvar k;
	generate
		for (k = 1; k < N; k++) begin : g_tap
			assign tick_o[k] = ~clear_i & (&div_q[k-1:0]);
		end
	endgenerate

endmodule

`default_nettype wire

// *** rtl/udqt_timer.sv ***
/*
 * 16-bit timer: interval / free-running counter or up/down counter
 * with internal prescaled clock or four external counting modes.
 * assumes software writes whole registers through the write ports
 * and that the pins are asynchronous to clk_i (20 MHz).
 */
// Overview of operation
// - after run set, first count clock keeps 0000, second gives 0001 or FFFF.
// - rewriting run as 1 while running neither clears nor stalls counting.
// - clearing run stops counting and forces the counter to 0000.
// - reset zeroes the counter and leaves it stopped.
// - general mode counts only the internal clock, one of six rates.
// - interval mode: match raises interrupt, next clock clears, then 0001.
// - free-running mode spans 0000..FFFF, sets overflow on wrap, continues.
// - up/down internal select codes 00, 01, 10 give clk/4, clk/8, clk/16.
// - up/down internal clock counts up with direction 0, down with 1.
// - direction write ignored while stopped unless run written in same write.
// - external clear works in up/down mode only, enabled, on selected edge.
// - external clear enable is unit mode bit 6; match clear is control bit 6.
// - with external clock, select codes 00..11 choose external modes 1..4.
// - mode 1: pulse edge counts down with direction high, up when low.
// - mode 2: pulse edge counts up, direction rising edge counts down.
// - mode 2: simultaneous events on both inputs hold the counter.
// - mode 3: direction sampled at pulse edge; low counts down, high up.
// - mode 4: both edges of both inputs count, direction from phase.
// - mode 4 ignores the pulse edge selection.
// - direction bit steers only internal-clock up/down counting.
// - external modes ignore direction writes; reads show current direction.
// - an underflow flag exists and is cleared by reset or software.
// - mode 4: simultaneous edges keep counting in the previous direction.
`timescale 1ns/1ps
`default_nettype none
`include "udqt_defs.svh"

module udqt_timer (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// register write ports
	input wire logic umr_wr_i,
	input wire logic [7:0] umr_wdata_i,
	input wire logic ccr_wr_i,
	input wire logic [7:0] ccr_wdata_i,
	input wire logic [15:0] period_compare_i,
	// external pins
	input wire logic count_pulse_input_i,
	input wire logic direction_input_i,
	input wire logic ext_clear_input_i,
	// status
	output logic [15:0] count_o,
	output logic [7:0] umr_rdata_o,
	output logic [7:0] ccr_rdata_o,
	output logic period_match_irq_o
);
	import udqt_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	udqt_pin_t pins [3];
	udqt_pin_t pp, dp, cp;
	logic [`UDQT_GP_TAPS-1:0] ticks;
	logic [7:0] umr_q, umr_d;
	logic run_q, run_d, mclr_q, mclr_d, ovf_q, ovf_d, udf_q, udf_d;
	logic dir_q, dir_d, ie_q, ie_d, xdir_q, xdir_d;
	logic [1:0] sel_q, sel_d;
	logic [15:0] count_q, count_d;
	logic started_q, started_d, hold_q, hold_d, irq_q, irq_d;
	logic [7:0] ccr_rd_q, ccr_rd_d;
	logic updown_mode, ext, int_tick, pv, xclr, up_ev, dn_ev, cnt_evt, match;
	udqt_ext_mode_t xmode;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// selected-edge decode, shared by pulse and clear pins
	function automatic logic edge_hit(input logic [1:0] sel,
		input udqt_pin_t p);
		unique case (sel)
			2'h0: edge_hit = p.fall;
			2'h1: edge_hit = p.rise;
			default: edge_hit = p.rise | p.fall;
		endcase
	endfunction

	udqt_pin_sync #(.W(3)) u_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pin_i({ext_clear_input_i, direction_input_i,
			count_pulse_input_i}),
		.pin_o(pins)
	);

	udqt_prescaler #(.N(`UDQT_GP_TAPS)) u_presc (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(~run_q),
		.tick_o(ticks)
	);

	// ---------------------------------------------------------------
	// count event decode
	// ---------------------------------------------------------------
	// mode, clock source and per-mode up/down events
	always_comb begin
		pp = pins[0];
		dp = pins[1];
		cp = pins[2];
		updown_mode = umr_q[`UDQT_UMR_MODE];
		ext = updown_mode & ie_q;
		xmode = udqt_ext_mode_t'(sel_q);
		int_tick = 1'b0;
		if (!updown_mode) begin
			if ({ie_q, sel_q} < 3'(`UDQT_GP_TAPS))
				int_tick = ticks[{ie_q, sel_q}];
		end else if (!ie_q && sel_q != `UDQT_UDC_SEL_NONE) begin
			int_tick = ticks[3'(sel_q) + 3'(`UDQT_UDC_TAP_BASE)];
		end
		pv = edge_hit(umr_q[`UDQT_UMR_PEDGE_HI:`UDQT_UMR_PEDGE_LO], pp);
		xclr = updown_mode & umr_q[`UDQT_UMR_XCLR_EN] &
			edge_hit(umr_q[`UDQT_UMR_CEDGE_HI:`UDQT_UMR_CEDGE_LO], cp);
		up_ev = 1'b0;
		dn_ev = 1'b0;
		if (!ext) begin
			up_ev = int_tick & ~(updown_mode & dir_q);
			dn_ev = int_tick & updown_mode & dir_q;
		end else begin
			unique case (xmode)
				UDQT_EXT_M1: begin
					dn_ev = pv & dp.level;
					up_ev = pv & ~dp.level;
				end
				UDQT_EXT_M2: begin
					up_ev = pv & ~dp.rise;
					dn_ev = dp.rise & ~pv;
				end
				UDQT_EXT_M3: begin
					dn_ev = pv & ~dp.level;
					up_ev = pv & dp.level;
				end
				UDQT_EXT_M4: begin
					// any edge counts; pulse edge select unused
					if ((pp.rise | pp.fall) && (dp.rise | dp.fall)) begin
						up_ev = ~xdir_q;
						dn_ev = xdir_q;
					end else if (pp.rise | pp.fall) begin
						up_ev = pp.level != dp.level;
						dn_ev = pp.level == dp.level;
					end else if (dp.rise | dp.fall) begin
						up_ev = pp.level == dp.level;
						dn_ev = pp.level != dp.level;
					end
				end
			endcase
		end
		cnt_evt = up_ev | dn_ev;
	end

	// ---------------------------------------------------------------
	// register and counter next state
	// ---------------------------------------------------------------
	always_comb begin
		umr_d = umr_q;
		run_d = run_q;
		mclr_d = mclr_q;
		ovf_d = ovf_q;
		udf_d = udf_q;
		dir_d = dir_q;
		ie_d = ie_q;
		sel_d = sel_q;
		xdir_d = xdir_q;
		count_d = count_q;
		started_d = started_q;
		hold_d = hold_q;
		irq_d = 1'b0;
		match = count_q == period_compare_i;
		if (umr_wr_i)
			umr_d = umr_wdata_i & `UDQT_UMR_MASK;
		if (ccr_wr_i) begin
			run_d = ccr_wdata_i[`UDQT_CCR_RUN];
			mclr_d = ccr_wdata_i[`UDQT_CCR_MCLR_EN];
			ie_d = ccr_wdata_i[`UDQT_CCR_IE];
			sel_d = ccr_wdata_i[`UDQT_CCR_SEL_HI:`UDQT_CCR_SEL_LO];
			if (!ccr_wdata_i[`UDQT_CCR_OVF])
				ovf_d = 1'b0;
			if (!ccr_wdata_i[`UDQT_CCR_UDF])
				udf_d = 1'b0;
			if (!ext)
				dir_d = ccr_wdata_i[`UDQT_CCR_DIR];
		end
		if (!run_q) begin
			count_d = `UDQT_CNT_ZERO;
			started_d = 1'b0;
			hold_d = 1'b0;
		end else begin
			if (xclr) begin
				count_d = `UDQT_CNT_ZERO;
			end else if (cnt_evt) begin
				if (ext)
					xdir_d = dn_ev;
				if (!started_q) begin
					started_d = 1'b1;
				end else if (!updown_mode && mclr_q && (hold_q || match)) begin
					count_d = `UDQT_CNT_ZERO;
				end else if (up_ev) begin
					count_d = count_q + 16'h0001;
					if (count_q == `UDQT_CNT_MAX)
						ovf_d = 1'b1;
				end else begin
					count_d = count_q - 16'h0001;
					if (count_q == `UDQT_CNT_ZERO)
						udf_d = 1'b1;
				end
			end
			// new match pulses the irq once; kept until a count clock uses it
			irq_d = match & ~hold_q;
			hold_d = match & ~(cnt_evt & started_q);
		end
		// direction bit only stays 1 while running in up/down mode
		if (!run_d || !umr_d[`UDQT_UMR_MODE])
			dir_d = 1'b0;
		if (!run_d)
			xdir_d = 1'b0;
		ccr_rd_d = {run_d, mclr_d, udf_d, ovf_d,
			(umr_d[`UDQT_UMR_MODE] && ie_d) ? xdir_d : dir_d,
			ie_d, sel_d};
	end

	// state registers
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			umr_q <= `UDQT_UMR_RESET;
			{run_q, mclr_q, udf_q, ovf_q, dir_q, ie_q, sel_q} <=
				`UDQT_CCR_RESET;
			ccr_rd_q <= `UDQT_CCR_RESET;
			xdir_q <= 1'b0;
			count_q <= `UDQT_CNT_ZERO;
			started_q <= 1'b0;
			hold_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			umr_q <= umr_d;
			{run_q, mclr_q, udf_q, ovf_q, dir_q, ie_q, sel_q} <=
				{run_d, mclr_d, udf_d, ovf_d, dir_d, ie_d, sel_d};
			ccr_rd_q <= ccr_rd_d;
			xdir_q <= xdir_d;
			count_q <= count_d;
			started_q <= started_d;
			hold_q <= hold_d;
			irq_q <= irq_d;
		end
	end

	// outputs straight from flops
	assign count_o = count_q;
	assign umr_rdata_o = umr_q;
	assign ccr_rdata_o = ccr_rd_q;
	assign period_match_irq_o = irq_q;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence s_first_clock;
		run_q && !started_q && cnt_evt && !xclr;
	endsequence

	sequence s_second_up;
		run_q && cnt_evt && up_ev && !xclr &&
			!(!updown_mode && mclr_q && (hold_q || match));
	endsequence

	property p_start;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_first_clock ##1 s_second_up |=> count_o == `UDQT_CNT_ONE;
	endproperty
	a_start: assert property (p_start)
		else $error("second count clock did not reach 0001");

	property p_stop;
		@(posedge clk_i) disable iff (!reset_n_i)
		!run_q |=> count_o == `UDQT_CNT_ZERO;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stopped counter not at 0000");

	property p_reset;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> count_o == `UDQT_CNT_ZERO && !run_q;
	endproperty
	a_reset: assert property (p_reset)
		else $error("counter not cleared by reset");

	property p_interval;
		@(posedge clk_i) disable iff (!reset_n_i)
		run_q && started_q && !updown_mode && mclr_q && (hold_q || match) &&
			cnt_evt
			|=> count_o == `UDQT_CNT_ZERO;
	endproperty
	a_interval: assert property (p_interval)
		else $error("interval match did not clear counter");

	property p_wrap;
		@(posedge clk_i) disable iff (!reset_n_i)
		run_q && started_q && !updown_mode && !mclr_q && cnt_evt &&
			count_q == `UDQT_CNT_MAX
			|=> count_o == `UDQT_CNT_ZERO && ovf_q;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("free-running wrap missing overflow");

	property p_dir_locked;
		@(posedge clk_i) disable iff (!reset_n_i)
		ccr_wr_i && !ccr_wdata_i[`UDQT_CCR_RUN] |=> !dir_q;
	endproperty
	a_dir_locked: assert property (p_dir_locked)
		else $error("direction bit set while stopped");

	property p_xclear;
		@(posedge clk_i) disable iff (!reset_n_i)
		run_q && xclr |=> count_o == `UDQT_CNT_ZERO;
	endproperty
	a_xclear: assert property (p_xclear)
		else $error("external clear ignored");

	property p_mode1_down;
		@(posedge clk_i) disable iff (!reset_n_i)
		run_q && started_q && ext && xmode == UDQT_EXT_M1 && pv &&
			dp.level && !xclr |=> count_q == $past(count_q) - 16'h0001;
	endproperty
	a_mode1_down: assert property (p_mode1_down)
		else $error("mode 1 did not count down");

	property p_mode2_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		run_q && ext && xmode == UDQT_EXT_M2 && pv && dp.rise && !xclr
			|=> $stable(count_q);
	endproperty
	a_mode2_hold: assert property (p_mode2_hold)
		else $error("mode 2 counted on simultaneous events");

endmodule

`default_nettype wire

// *** test/udqt_pin_source.sv ***
/*
 * pin source model: shaft encoder, count/direction and clear pins.
 * assumes a free-running clk_i; the bench calls drive() to move pins.
 */
`timescale 1ns/1ps
`default_nettype none

module udqt_pin_source (
	// clock
	input wire logic clk_i,
	// pins towards the timer
	output logic pulse_o,
	output logic dir_o,
	output logic clr_o
);
	// new levels just after an edge, held 6 clocks (min is 2)
	task automatic drive(input logic p, input logic d, input logic c);
		@(posedge clk_i);
		#1;
		pulse_o = p;
		dir_o = d;
		clr_o = c;
		repeat (6) @(posedge clk_i);
		#1;
	endtask

	// idle levels: clear pin parked high
	initial begin
		pulse_o = 1'b0;
		dir_o = 1'b0;
		clr_o = 1'b1;
	end
endmodule

`default_nettype wire

// *** test/udqt_timer_tb_top.sv ***
/*
 * self-checking bench of the up/down quadrature timer.
 * assumes the pin source model and the timer design are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR %0t mismatch got %h exp %h", $time, (a), (b)); end end

module udqt_timer_tb_top;
	import udqt_pkg::*;

	// ---------------------------------------------------------------
	// signals and instances
	// ---------------------------------------------------------------
	logic clk_i, reset_n_i, umr_wr_i, ccr_wr_i, period_match_irq_o;
	logic [7:0] umr_wdata_i, ccr_wdata_i, umr_rdata_o, ccr_rdata_o;
	logic [15:0] period_compare_i, count_o, ex;
	logic first, ldn, p, d, np, nd;
	wire logic pulse, dir, clr;
	int fail_count = 0;
	int n_checks = 0;
	int t, r, dv;

	udqt_pin_source i_src (
		.clk_i(clk_i),
		.pulse_o(pulse),
		.dir_o(dir),
		.clr_o(clr)
	);

	udqt_timer i_dut (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.umr_wr_i(umr_wr_i),
		.umr_wdata_i(umr_wdata_i),
		.ccr_wr_i(ccr_wr_i),
		.ccr_wdata_i(ccr_wdata_i),
		.period_compare_i(period_compare_i),
		.count_pulse_input_i(pulse),
		.direction_input_i(dir),
		.ext_clear_input_i(clr),
		.count_o(count_o),
		.umr_rdata_o(umr_rdata_o),
		.ccr_rdata_o(ccr_rdata_o),
		.period_match_irq_o(period_match_irq_o)
	);

	// ---------------------------------------------------------------
	// tasks and model
	// ---------------------------------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one-cycle write strobe to the mode (u=1) or control register
	task automatic wr(input bit u, input logic [7:0] v);
		@(posedge clk_i);
		#1;
		umr_wr_i = u;
		ccr_wr_i = !u;
		umr_wdata_i = v;
		ccr_wdata_i = v;
		@(posedge clk_i);
		#1;
		umr_wr_i = 1'b0;
		ccr_wr_i = 1'b0;
	endtask

	// count delta of one pin step in external mode m
	function automatic int dlt(int m, logic op, od, np, nd, ldn);
		logic pr, pe, dr, de;
		pr = !op && np;
		pe = op != np;
		dr = !od && nd;
		de = od != nd;
		case (m)
			0: return pr ? (nd ? -1 : 1) : 0;
			1: return (pr && dr) ? 0 : pr ? 1 : dr ? -1 : 0;
			2: return pr ? (nd ? 1 : -1) : 0;
			default: return (pe && de) ? (ldn ? -1 : 1) :
				pe ? (np != nd ? 1 : -1) : de ? (np == nd ? 1 : -1) : 0;
		endcase
	endfunction

	// general mode, every clock: model count and match pulse per cycle
	task automatic gp(input logic [15:0] cmp, input logic [7:0] c);
		int e, pe;
		period_compare_i = cmp;
		wr(0, c);
		pe = -1;
		for (int k = 1; k <= 20; k++) begin
			@(posedge clk_i);
			#1;
			e = c[6] ? (k - 1) % (cmp + 1) : k - 1;
			`CHK(count_o, 16'(e))
			if (k >= 3) `CHK(period_match_irq_o, pe == cmp)
			pe = e;
		end
	endtask

	// cycles until count_o moves, bounded
	task automatic wait_chg(output int n);
		logic [15:0] v;
		v = count_o;
		n = 0;
		while (count_o === v && n < 100) begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog and main sequence
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		#4000000; // 80k clocks: the 16-bit wrap alone takes 65k
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		results();
	end

	initial begin
		void'($urandom(32'h36ac62a1));
		reset_n_i = 1'b0;
		umr_wr_i = 1'b0;
		ccr_wr_i = 1'b0;
		umr_wdata_i = 8'h00;
		ccr_wdata_i = 8'h00;
		period_compare_i = 16'hffff;
		repeat (19) @(posedge clk_i);
		#1;
		`CHK(count_o, 16'h0000)
		`CHK(ccr_rdata_o, 8'h00)
		`CHK(umr_rdata_o, 8'h00)
		@(posedge clk_i);
		#1;
		reset_n_i = 1'b1;
		// free run, rewrite of run, stop, then interval of 4
		gp(16'hffff, 8'h80);
		wr(0, 8'h80);
		`CHK(count_o, 16'h0015)
		wr(0, 8'h00);
		@(posedge clk_i);
		#1;
		`CHK(count_o, 16'h0000)
		`CHK(ccr_rdata_o, 8'h00)
		// full free-running span, wrap sets overflow
		wr(0, 8'h80);
		repeat (65536) @(posedge clk_i);
		#1;
		`CHK(count_o, 16'hffff)
		@(posedge clk_i);
		#1;
		`CHK(count_o, 16'h0000)
		`CHK(ccr_rdata_o[4], 1'b1)
		wr(0, 8'h00);
		gp(16'h0003, 8'hc0);
		wr(0, 8'h00);
		// up/down internal: direction refused while stopped, then rates
		wr(1, 8'h80);
		wr(0, 8'h08);
		`CHK(ccr_rdata_o[3], 1'b0)
		for (int s = 0; s < 3; s++) begin
			wr(0, 8'h00);
			wr(0, 8'h80 | ((s != 1) ? 8'h08 : 8'h00) | 8'(s));
			wait_chg(t);
			`CHK(count_o, (s != 1) ? 16'hffff : 16'h0001)
			`CHK(ccr_rdata_o[3], s != 1)
			wait_chg(t);
			`CHK(t, 4 << s)
			`CHK(count_o, (s != 1) ? 16'hfffe : 16'h0002)
			`CHK(ccr_rdata_o[5], s != 1)
		end
		// external modes 1..4 with random pin steps and a clear
		for (int m = 0; m < 4; m++) begin
			wr(0, 8'h00);
			wr(1, (m == 3) ? 8'hc0 : 8'hc1);
			i_src.drive(1'b0, 1'b0, 1'b1);
			wr(0, 8'h84 | 8'(m));
			ex = 16'h0000;
			first = 1'b1;
			ldn = 1'b0;
			p = 1'b0;
			d = 1'b0;
			for (int i = 0; i < 24; i++) begin
				r = $urandom % 8;
				np = (m < 3) ? r[0] : (r == 0 || r[0]) ? !p : p;
				nd = (m < 3) ? r[1] : (r == 0 || !r[0]) ? !d : d;
				if ((m == 0 || m == 2) && np != p)
					nd = d;
				if (i == 0) begin
					np = 1'b1;
					nd = 1'b0;
				end
				if (i == 6) begin
					np = p;
					nd = d;
				end
				dv = dlt(m, p, d, np, nd, ldn);
				i_src.drive(np, nd, i != 6);
				if (i == 6)
					ex = 16'h0000;
				else if (dv != 0 && first)
					first = 1'b0;
				else if (dv != 0) begin
					ex = ex + 16'(dv);
					ldn = dv < 0;
				end
				`CHK(count_o, ex)
				if (dv != 0 && i > 0) `CHK(ccr_rdata_o[3], ldn)
				p = np;
				d = nd;
			end
		end
		wr(0, 8'h00);
		results();
	end
endmodule

`default_nettype wire
